// ### common/pin_mux_pkg.sv
// Package: constants and carriers for the indicator/general I/O pin mux and serial pin pair
// Function
// - Indicator enable set routes the shared pin to the indicator function.
// - Indicator enable clear routes the shared pin to general I/O zero.
// - General I/O drives push-pull, open-drain, or acts as input per configuration.
// - Indicator buffer is push-pull or open-drain/open-source per function field.
// - Open-drain/open-source indicator polarity comes from the latched strap.
// - Strap 0 gives active-high indicator; strap 1 gives active-low.
// - Same strap sets port 1 crossover default: 0 off, 1 on.
// - Straps are captured at power-on reset and at both reset-pin assertion and reset-pin release.
// - EEPROM loader may replace latched strap values afterwards.
// - EEPROM access drives serial clock open-drain and samples it.
// - Slave mode: serial clock is input only, never driven.
// - Slave mode: serial data is bidirectional open-drain.
package pin_mux_pkg;

  localparam logic STRAP_RESET_VALUE = 1'h0;
  localparam logic [1:0] SYNC_RESET_VALUE = 2'h0;

  // Indicator function field: 0 push-pull, 1 open-drain/open-source
  localparam logic IND_FUN_PUSH_PULL = 1'h0;

  typedef enum logic [1:0] {
    GIO_INPUT      = 2'h0,
    GIO_PUSH_PULL  = 2'h1,
    GIO_OPEN_DRAIN = 2'h2
  } gio_mode_t;

  typedef enum logic [2:0] {
    SER_IDLE   = 3'h1,
    SER_EEPROM = 3'h2,
    SER_SLAVE  = 3'h4
  } ser_mode_t;

  typedef struct packed {
    logic      indicator_enable;
    logic      indicator_open_drain;
    gio_mode_t gio_mode;
    logic      gio_out_value;
  } pin_cfg_t;

  typedef struct packed {
    logic pin_out;
    logic pin_oe_n;
  } pad_drive_t;

endpackage

// ### hdl/led_gpio_strap_pin_mux.sv
// Module: shared indicator/general I/O pin mux, strap latch and serial management pin steering
`timescale 1ns/1ns
module led_gpio_strap_pin_mux
(
  input  wire logic                   core_clk,
  input  wire logic                   sys_rst,
  input  wire logic                   reset_input_low,
  input  wire pin_mux_pkg::pin_cfg_t  indicator_config_reg,
  input  wire logic                   indicator_out_zero,
  output logic                        general_io_zero,
  input  wire logic                   shared_pin_in,
  output pin_mux_pkg::pad_drive_t     shared_pin,
  output logic                        port1_crossover_default,
  output logic                        strap_polarity,
  input  wire logic                   loader_override_valid,
  input  wire logic                   loader_override_value,
  input  wire logic                   serial_eeprom_active,
  input  wire logic                   serial_slave_mode,
  input  wire logic                   eeprom_clock_out,
  input  wire logic                   eeprom_data_out,
  input  wire logic                   slave_data_out,
  output logic                        eeprom_serial_clock,
  output logic                        eeprom_serial_data,
  input  wire logic                   serial_clock_pin_in,
  input  wire logic                   serial_data_pin_in,
  output pin_mux_pkg::pad_drive_t     serial_clock_pin,
  output pin_mux_pkg::pad_drive_t     serial_data_pin
);
  import pin_mux_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [1:0] pin_sync;
    logic [1:0] rst_pin_sync;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       strap;
    logic       capture_pending;
    logic       gio_in;
    ser_mode_t  ser_mode;
  } state_t;

  state_t cur;
  state_t next_cur;

  ////////////////////////////////////////////////////////////////////////////////
  // Open-drain helper: drive low means enable low, otherwise release
  function automatic pad_drive_t open_drain(input logic level);
    pad_drive_t d;
    d.pin_out  = 1'h0;
    d.pin_oe_n = level;
    return d;
  endfunction

  always_comb
  begin
    next_cur              = cur;
    next_cur.pin_sync     = {cur.pin_sync[0], shared_pin_in};
    next_cur.rst_pin_sync = {cur.rst_pin_sync[0], reset_input_low};
    next_cur.scl_sync     = {cur.scl_sync[0], serial_clock_pin_in};
    next_cur.sda_sync     = {cur.sda_sync[0], serial_data_pin_in};
    next_cur.gio_in       = cur.pin_sync[1];
    // Strap taken from the pad sync, which has followed the released pin through reset
    if (cur.capture_pending)
    begin
      next_cur.strap           = cur.pin_sync[1];
      next_cur.capture_pending = 1'h0;
    end
    else if (cur.rst_pin_sync[1] && !cur.rst_pin_sync[0])
    begin
      next_cur.capture_pending = 1'h1;
    end
    else if (!cur.rst_pin_sync[1] && cur.rst_pin_sync[0])
    begin
      next_cur.capture_pending = 1'h1;
    end
    else if (loader_override_valid)
    begin
      next_cur.strap = loader_override_value;
    end
    // Slave mode wins when both are requested, as the master owns the bus
    if (serial_slave_mode)
      next_cur.ser_mode = SER_SLAVE;
    else if (serial_eeprom_active)
      next_cur.ser_mode = SER_EEPROM;
    else
      next_cur.ser_mode = SER_IDLE;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      cur                 <= '0;
      // Shared-pin and reset-pin syncs keep shifting through reset: a cleared sync would latch a false strap
      // and fake a reset-pin release edge. Limitation: reset must last three edges or more.
      cur.pin_sync        <= next_cur.pin_sync;
      cur.rst_pin_sync    <= next_cur.rst_pin_sync;
      cur.scl_sync        <= SYNC_RESET_VALUE;
      cur.sda_sync        <= SYNC_RESET_VALUE;
      cur.strap           <= STRAP_RESET_VALUE;
      cur.capture_pending <= 1'h1;
      cur.ser_mode        <= SER_IDLE;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Shared pin drive
  always_comb
  begin
    shared_pin = '{pin_out: 1'h0, pin_oe_n: 1'h1};
    if (cur.capture_pending)
      shared_pin = '{pin_out: 1'h0, pin_oe_n: 1'h1};
    else if (indicator_config_reg.indicator_enable)
    begin
      if (indicator_config_reg.indicator_open_drain == IND_FUN_PUSH_PULL)
        shared_pin = '{pin_out: indicator_out_zero, pin_oe_n: 1'h0};
      else
        // Drive only the active level; strap 1 sinks (active low), strap 0 sources
        shared_pin = '{pin_out: ~cur.strap, pin_oe_n: ~indicator_out_zero};
    end
    else
    begin
      unique case (indicator_config_reg.gio_mode)
        GIO_PUSH_PULL:  shared_pin = '{pin_out: indicator_config_reg.gio_out_value, pin_oe_n: 1'h0};
        GIO_OPEN_DRAIN: shared_pin = open_drain(indicator_config_reg.gio_out_value);
        default:        shared_pin = '{pin_out: 1'h0, pin_oe_n: 1'h1};
      endcase
    end
  end

  assign general_io_zero         = cur.gio_in;
  assign port1_crossover_default = cur.strap;
  assign strap_polarity          = cur.strap;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial pin pair steering
  always_comb
  begin
    serial_clock_pin = '{pin_out: 1'h0, pin_oe_n: 1'h1};
    serial_data_pin  = '{pin_out: 1'h0, pin_oe_n: 1'h1};
    unique case (cur.ser_mode)
      SER_EEPROM:
      begin
        serial_clock_pin = open_drain(eeprom_clock_out);
        serial_data_pin  = open_drain(eeprom_data_out);
      end
      SER_SLAVE:
      begin
        serial_clock_pin = '{pin_out: 1'h0, pin_oe_n: 1'h1};
        serial_data_pin  = open_drain(slave_data_out);
      end
      SER_IDLE:
      begin
        serial_clock_pin = '{pin_out: 1'h0, pin_oe_n: 1'h1};
      end
      default:
      begin
        serial_clock_pin = '{pin_out: 1'h0, pin_oe_n: 1'h1};
      end
    endcase
  end

  assign eeprom_serial_clock = cur.scl_sync[1];
  assign eeprom_serial_data  = cur.sda_sync[1];

  ////////////////////////////////////////////////////////////////////////////////
  a_led_route_pp: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cur.capture_pending && indicator_config_reg.indicator_enable && !indicator_config_reg.indicator_open_drain)
    |-> (!shared_pin.pin_oe_n && shared_pin.pin_out == indicator_out_zero))
    else $error("indicator push-pull drive wrong");
  a_gio_route: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cur.capture_pending && !indicator_config_reg.indicator_enable && indicator_config_reg.gio_mode == GIO_PUSH_PULL)
    |-> (shared_pin.pin_out == indicator_config_reg.gio_out_value && !shared_pin.pin_oe_n))
    else $error("general io push-pull drive wrong");
  a_gio_input: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!indicator_config_reg.indicator_enable && indicator_config_reg.gio_mode == GIO_INPUT) |-> shared_pin.pin_oe_n)
    else $error("general io input is driven");
  a_gio_od_high: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!indicator_config_reg.indicator_enable && indicator_config_reg.gio_mode == GIO_OPEN_DRAIN)
    |-> (shared_pin.pin_out == 1'h0 && shared_pin.pin_oe_n == indicator_config_reg.gio_out_value))
    else $error("general io open-drain drive wrong");
  a_led_od_pol: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cur.capture_pending && indicator_config_reg.indicator_enable && indicator_config_reg.indicator_open_drain
     && indicator_out_zero) |-> (!shared_pin.pin_oe_n && shared_pin.pin_out == !strap_polarity))
    else $error("indicator open-drain polarity wrong");
  a_led_od_off: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cur.capture_pending && indicator_config_reg.indicator_enable && indicator_config_reg.indicator_open_drain
     && !indicator_out_zero) |-> shared_pin.pin_oe_n)
    else $error("indicator open-drain not released when off");
  a_strap_mdix: assert property (@(posedge core_clk) disable iff (sys_rst)
    cur.capture_pending |=> (port1_crossover_default == $past(cur.pin_sync[1])))
    else $error("crossover default not taken from strap");
  a_strap_capture: assert property (@(posedge core_clk) disable iff (sys_rst)
    cur.capture_pending |=> (strap_polarity == $past(cur.pin_sync[1])))
    else $error("strap not captured");
  a_strap_override: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cur.capture_pending && cur.rst_pin_sync[1] == cur.rst_pin_sync[0] && loader_override_valid)
    |=> strap_polarity == $past(loader_override_value))
    else $error("loader override lost");
  a_strap_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!cur.capture_pending && !loader_override_valid) |=> $stable(strap_polarity))
    else $error("strap changed without cause");
  a_eeprom_scl: assert property (@(posedge core_clk) disable iff (sys_rst)
    (serial_eeprom_active && !serial_slave_mode) ##1 (serial_eeprom_active && !serial_slave_mode && !eeprom_clock_out)
    |-> !serial_clock_pin.pin_oe_n)
    else $error("eeprom clock not pulled low");
  a_slave_scl: assert property (@(posedge core_clk) disable iff (sys_rst)
    cur.ser_mode == SER_SLAVE |-> serial_clock_pin.pin_oe_n)
    else $error("slave clock driven");
  a_slave_sda: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cur.ser_mode == SER_SLAVE) |-> (serial_data_pin.pin_oe_n == slave_data_out && !serial_data_pin.pin_out))
    else $error("slave data drive wrong");

  c_led_od: cover property (@(posedge core_clk) disable iff (sys_rst)
    indicator_config_reg.indicator_enable && indicator_config_reg.indicator_open_drain && strap_polarity);
  c_reset_pin: cover property (@(posedge core_clk) disable iff (sys_rst) cur.capture_pending ##1 !cur.capture_pending);
  c_override: cover property (@(posedge core_clk) disable iff (sys_rst) loader_override_valid);
  c_slave: cover property (@(posedge core_clk) disable iff (sys_rst) cur.ser_mode == SER_SLAVE);

endmodule // led_gpio_strap_pin_mux

// ### tb/pin_partner.sv
// Far-side model: strap resistor, pulled-up serial lines and an external master
`timescale 1ns/1ns
module pin_partner
  import pin_mux_pkg::*;
(
  input  wire logic       strap_pull,
  input  wire pad_drive_t shared_pin,
  output logic            shared_pin_in,
  input  wire pad_drive_t serial_clock_pin,
  input  wire pad_drive_t serial_data_pin,
  input  wire logic       master_scl_low,
  input  wire logic       master_sda_low,
  output logic            serial_clock_pin_in,
  output logic            serial_data_pin_in
);
  // Released pin shows the strap resistor level, never the last driven value
  assign shared_pin_in = shared_pin.pin_oe_n ? strap_pull : shared_pin.pin_out;
  // Wired-AND with pull-up: any party pulling low wins
  assign serial_clock_pin_in = !((!serial_clock_pin.pin_oe_n && !serial_clock_pin.pin_out)
                                 || master_scl_low);
  assign serial_data_pin_in = !((!serial_data_pin.pin_oe_n && !serial_data_pin.pin_out) || master_sda_low);
endmodule // pin_partner

// ### tb/led_gpio_strap_pin_mux_test.sv
// Testbench for the shared indicator/general I/O pin mux
`timescale 1ns/1ns
module led_gpio_strap_pin_mux_test;
  import pin_mux_pkg::*;
  typedef struct packed {pin_cfg_t c; logic l; logic [1:0] e; logic care;} row_t;
  logic core_clk, sys_rst, rst_n, lit, ov_v, ov_d, ee_act, slv, ee_clk, ee_dat, sl_dat, pull, m_scl, m_sda;
  logic gio, pin_in, xover, pol, ee_c, ee_d, scl_in, sda_in;
  pin_cfg_t   cfg;
  pad_drive_t pin, scl, sda;
  int miscompares = 0;
  int num_checks = 0;
  row_t rows [9] = '{
    '{'{1'h1, 1'h0, GIO_INPUT, 1'h0}, 1'h1, 2'h2, 1'h1},
    '{'{1'h1, 1'h1, GIO_INPUT, 1'h0}, 1'h1, 2'h2, 1'h1},
    '{'{1'h1, 1'h1, GIO_INPUT, 1'h0}, 1'h0, 2'h1, 1'h0},
    '{'{1'h0, 1'h0, GIO_PUSH_PULL, 1'h1}, 1'h0, 2'h2, 1'h1},
    '{'{1'h0, 1'h0, GIO_PUSH_PULL, 1'h0}, 1'h0, 2'h0, 1'h1},
    '{'{1'h0, 1'h0, GIO_OPEN_DRAIN, 1'h0}, 1'h0, 2'h0, 1'h1},
    '{'{1'h0, 1'h0, GIO_OPEN_DRAIN, 1'h1}, 1'h0, 2'h1, 1'h0},
    '{'{1'h0, 1'h0, GIO_INPUT, 1'h1}, 1'h1, 2'h1, 1'h0},
    '{'{1'h0, 1'h0, gio_mode_t'(2'h3), 1'h1}, 1'h0, 2'h1, 1'h0}};

  led_gpio_strap_pin_mux uut (.core_clk(core_clk), .sys_rst(sys_rst), .reset_input_low(rst_n),
    .indicator_config_reg(cfg), .indicator_out_zero(lit), .general_io_zero(gio), .shared_pin_in(pin_in),
    .shared_pin(pin), .port1_crossover_default(xover), .strap_polarity(pol), .loader_override_valid(ov_v),
    .loader_override_value(ov_d), .serial_eeprom_active(ee_act), .serial_slave_mode(slv),
    .eeprom_clock_out(ee_clk), .eeprom_data_out(ee_dat), .slave_data_out(sl_dat), .eeprom_serial_clock(ee_c),
    .eeprom_serial_data(ee_d), .serial_clock_pin_in(scl_in), .serial_data_pin_in(sda_in),
    .serial_clock_pin(scl), .serial_data_pin(sda));
  pin_partner far (.strap_pull(pull), .shared_pin(pin), .shared_pin_in(pin_in), .serial_clock_pin(scl),
    .serial_data_pin(sda), .master_scl_low(m_scl), .master_sda_low(m_sda), .serial_clock_pin_in(scl_in),
    .serial_data_pin_in(sda_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [1:0] e, input logic [1:0] g);
    num_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'h0;
    forever #50 core_clk = ~core_clk;
  end

  // Run needs about 70 cycles; generous margin
  initial
  begin
    #200000;
    miscompares++;
    test_done;
  end

  initial
  begin
    {sys_rst, rst_n, lit, ov_v, ov_d, ee_act, slv} = 7'h60;
    {ee_clk, ee_dat, sl_dat, pull, m_scl, m_sda} = 6'h38;
    cfg = '0;
    wait_n(13);
    sys_rst = 1'h0;
    wait_n(3);
    chk("strap_polarity", 2'h0, {1'h0, pol});
    foreach (rows[i])
    begin
      cfg = rows[i].c;
      lit = rows[i].l;
      #10;
      if (rows[i].care)
        chk("shared_pin", rows[i].e, pin);
      else
        chk("pin_oe_n", {1'h0, rows[i].e[0]}, {1'h0, pin.pin_oe_n});
      wait_n(1);
    end
    {ov_v, ov_d} = 2'h3;
    wait_n(1);
    ov_v = 1'h0;
    chk("strap_polarity", 2'h1, {1'h0, pol});
    chk("crossover", 2'h1, {1'h0, xover});
    cfg = '{1'h1, 1'h1, GIO_INPUT, 1'h0};
    lit = 1'h1;
    #10 chk("shared_pin", 2'h0, pin);
    lit = 1'h0;
    #10 chk("pin_oe_n", 2'h1, {1'h0, pin.pin_oe_n});
    cfg.indicator_enable = 1'h0;
    wait_n(5);
    chk("strap_polarity", 2'h1, {1'h0, pol});
    chk("general_io_zero", 2'h0, {1'h0, gio});
    pull = 1'h1;
    wait_n(4);
    chk("general_io_zero", 2'h1, {1'h0, gio});
    // The strap level at reset-pin release decides, not the level at its assertion
    rst_n = 1'h0;
    wait_n(4);
    {rst_n, pull} = 2'h2;
    wait_n(6);
    chk("strap_polarity", 2'h0, {1'h0, pol});
    chk("crossover", 2'h0, {1'h0, xover});
    pull = 1'h1;
    sys_rst = 1'h1;
    wait_n(4);
    sys_rst = 1'h0;
    wait_n(3);
    chk("strap_polarity", 2'h1, {1'h0, pol});
    {ee_act, ee_clk, ee_dat} = 3'h4;
    wait_n(1);
    chk("scl_drive", 2'h0, scl);
    chk("sda_drive", 2'h0, sda);
    wait_n(4);
    chk("eeprom_serial_clock", 2'h0, {1'h0, ee_c});
    ee_clk = 1'h1;
    wait_n(1);
    chk("scl_oe_n", 2'h1, {1'h0, scl.pin_oe_n});
    wait_n(4);
    chk("eeprom_serial_clock", 2'h1, {1'h0, ee_c});
    // Slave mode must ignore an EEPROM clock request still pulling low
    {slv, ee_clk, sl_dat} = 3'h4;
    wait_n(1);
    chk("scl_oe_n", 2'h1, {1'h0, scl.pin_oe_n});
    chk("sda_drive", 2'h0, sda);
    {sl_dat, m_sda} = 2'h3;
    wait_n(4);
    chk("sda_oe_n", 2'h1, {1'h0, sda.pin_oe_n});
    chk("eeprom_serial_data", 2'h0, {1'h0, ee_d});
    {m_scl, m_sda} = 2'h2;
    wait_n(4);
    chk("eeprom_serial_clock", 2'h0, {1'h0, ee_c});
    chk("eeprom_serial_data", 2'h1, {1'h0, ee_d});
    test_done;
  end
endmodule // led_gpio_strap_pin_mux_test
